// >>> sfmc_ctrl.sv
// Stepper driver fault, stall mode and power state control with Wishbone registers
`timescale 1ns/100ps
`default_nettype none
module sfmc_ctrl (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Control pins
  input  wire logic                    sleep_in_n,
  input  wire logic                    enable_in,
  input  wire sfmc_pkg::sfmc_smode_type stall_mode_select,
  input  wire logic                    stall_report_in,
  input  wire logic [sfmc_pkg::TH_W-1:0] torque_threshold_in,
  // Sensed conditions
  input  wire sfmc_pkg::sfmc_sense_type sense,
  // Outputs
  output logic                         stall_report_out,
  output logic                         stall_report_oe_n,
  output logic [sfmc_pkg::TH_W-1:0]    torque_threshold_pin,
  output logic                         torque_threshold_oe_n,
  output logic                         fault_out_n,
  output logic                         bridge_enable,
  output logic                         outputs_hiz,
  output logic                         charge_pump_enable,
  output logic                         core_logic_enable,
  output logic                         inputs_ready,
  output logic                         irq
);
  sfmc_pkg::sfmc_state_type s_reg, s_next;

  // Sleep pin low-time classifier
  function automatic logic is_reset_pulse(input logic [sfmc_pkg::CNT_W-1:0] n);
    is_reset_pulse = n >= sfmc_pkg::CNT_W'(sfmc_pkg::PULSE_MIN_CYC);
  endfunction

  // Electrical cycle count constant at counter width
  function automatic logic [sfmc_pkg::EC_W-1:0] ec_const(input int v);
    ec_const = sfmc_pkg::EC_W'(v);
  endfunction

  logic wr;
  logic stall_enable, stall_event, fault_any;
  logic [3:0] ev;
  logic [sfmc_pkg::CNT_W-1:0] low_time;

  // Next state; clear pulse never touches pump or core logic enable
  always_comb begin
    s_next = s_reg;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack;
    ev = 4'h0;
    low_time = s_reg.low_cnt;
    // Wishbone: ack one cycle after request, drops next cycle
    s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.dat = 32'h0;
    // Sleep pin timing
    if (!sleep_in_n) begin
      if (s_reg.low_cnt != sfmc_pkg::CNT_W'(sfmc_pkg::SLEEP_DLY_CYC))
        s_next.low_cnt = s_reg.low_cnt + 1'b1;
    end else begin
      s_next.low_cnt = '0;
    end
    unique case (s_reg.pwr)
      sfmc_pkg::SFMC_PW_SLEEP: begin
        s_next.wake_cnt = '0;
        if (sleep_in_n) begin
          s_next.pwr = sfmc_pkg::SFMC_PW_WAKING;
          s_next.ol_latch = 1'b0;
          s_next.stall_latch = 1'b0;
        end
      end
      sfmc_pkg::SFMC_PW_WAKING: begin
        if (!sleep_in_n) s_next.pwr = sfmc_pkg::SFMC_PW_LOWPIN;
        else if (s_reg.wake_cnt == sfmc_pkg::CNT_W'(sfmc_pkg::WAKE_DLY_CYC - 1))
          s_next.pwr = sfmc_pkg::SFMC_PW_ACTIVE;
        else s_next.wake_cnt = s_reg.wake_cnt + 1'b1;
      end
      sfmc_pkg::SFMC_PW_ACTIVE: begin
        if (!sleep_in_n) s_next.pwr = sfmc_pkg::SFMC_PW_LOWPIN;
      end
      sfmc_pkg::SFMC_PW_LOWPIN: begin
        // Sleep only after full delay; a pulse of PULSE_MIN_CYC or more just clears faults
        if (s_reg.low_cnt == sfmc_pkg::CNT_W'(sfmc_pkg::SLEEP_DLY_CYC))
          s_next.pwr = sfmc_pkg::SFMC_PW_SLEEP;
        else if (sleep_in_n) begin
          s_next.pwr = s_reg.wake_cnt == sfmc_pkg::CNT_W'(sfmc_pkg::WAKE_DLY_CYC - 1)
                     ? sfmc_pkg::SFMC_PW_ACTIVE : sfmc_pkg::SFMC_PW_WAKING;
          if (is_reset_pulse(low_time)) begin
            s_next.ol_latch = 1'b0;
            s_next.stall_latch = 1'b0;
          end
        end
      end
    endcase
    // Open load timer, only while bridge drives
    if (sense.coil_low && s_reg.bridge_on) begin
      if (s_reg.ol_cnt == sfmc_pkg::CNT_W'(sfmc_pkg::OL_DLY_CYC)) begin
        s_next.ol_latch = 1'b1;
        ev[0] = !s_reg.ol_latch;
      end else s_next.ol_cnt = s_reg.ol_cnt + 1'b1;
    end else s_next.ol_cnt = '0;
    // Stall detection suspended by other faults
    fault_any = s_reg.ol_latch || sense.over_temp || sense.supply_low || sense.other_fault;
    stall_enable = s_reg.logic_on && !fault_any
                && (stall_mode_select == sfmc_pkg::SFMC_SM_COUNT
                 || stall_mode_select == sfmc_pkg::SFMC_SM_THRESH);
    stall_event = stall_enable && sense.stall_seen && !s_reg.stall_latch;
    if (stall_event) s_next.stall_latch = 1'b1;
    if (!stall_enable && !(s_reg.stall_latch && stall_mode_select != sfmc_pkg::SFMC_SM_LEARN))
      s_next.stall_latch = 1'b0;
    ev[1] = sense.over_temp && s_reg.pump_on; // Pump still on: a fresh trip
    ev[2] = stall_event;
    // Learning: 32 unloaded cycles then 16 stalled
    if (stall_mode_select != sfmc_pkg::SFMC_SM_LEARN || !s_reg.logic_on) begin
      s_next.learn = sfmc_pkg::SFMC_LS_IDLE;
      s_next.ec_cnt = '0;
    end else begin
      unique case (s_reg.learn)
        sfmc_pkg::SFMC_LS_IDLE: s_next.learn = sfmc_pkg::SFMC_LS_RUN;
        sfmc_pkg::SFMC_LS_RUN: if (sense.elec_cycle) begin
          if (s_reg.ec_cnt == ec_const(sfmc_pkg::LEARN_RUN_CYC - 1)) begin
            s_next.learn = sfmc_pkg::SFMC_LS_STALL;
            s_next.steady_cnt = sense.torque_count;
            s_next.ec_cnt = '0;
          end else s_next.ec_cnt = s_reg.ec_cnt + 1'b1;
        end
        sfmc_pkg::SFMC_LS_STALL: if (sense.elec_cycle) begin
          if (s_reg.ec_cnt == ec_const(sfmc_pkg::LEARN_STALL_CYC - 1)) begin
            s_next.learn = sfmc_pkg::SFMC_LS_DONE;
            s_next.thresh = sfmc_pkg::TH_W'(({1'b0, s_reg.steady_cnt}
                          + {1'b0, sense.torque_count}) >> 1);
            s_next.learned = 1'b1;
            ev[3] = 1'b1;
          end else s_next.ec_cnt = s_reg.ec_cnt + 1'b1;
        end
        sfmc_pkg::SFMC_LS_DONE: s_next.learn = sfmc_pkg::SFMC_LS_DONE;
      endcase
    end
    if (stall_mode_select == sfmc_pkg::SFMC_SM_THRESH)
      s_next.thresh = torque_threshold_in;
    // Outputs from state
    s_next.logic_on = s_next.pwr != sfmc_pkg::SFMC_PW_SLEEP;
    s_next.pump_on = s_next.logic_on && !sense.over_temp && !sense.supply_low;
    s_next.bridge_on = s_next.pump_on && enable_in && !sense.other_fault
                    && s_next.pwr == sfmc_pkg::SFMC_PW_ACTIVE;
    s_next.outputs_hiz = !s_next.bridge_on;
    s_next.inputs_ready = s_next.pwr == sfmc_pkg::SFMC_PW_ACTIVE;
    s_next.fault_n = !(s_next.ol_latch || sense.over_temp || sense.supply_low
                   || sense.other_fault
                   || (s_next.stall_latch && stall_report_in));
    // Report pin: open drain, oe_n low pulls low
    if (stall_mode_select == sfmc_pkg::SFMC_SM_LEARN)
      s_next.rep_oe_n = s_next.learn != sfmc_pkg::SFMC_LS_DONE;
    else if (stall_mode_select == sfmc_pkg::SFMC_SM_DISABLE)
      s_next.rep_oe_n = 1'b0;
    else s_next.rep_oe_n = s_next.stall_latch;
    s_next.th_drive = stall_mode_select != sfmc_pkg::SFMC_SM_THRESH;
    s_next.th_out = stall_mode_select == sfmc_pkg::SFMC_SM_LEARN
                  ? (s_next.learn == sfmc_pkg::SFMC_LS_DONE ? s_next.thresh : '0)
                  : sense.torque_count;
    // Registers: write one clears status, set wins
    if (wr && wb_adr_i == sfmc_pkg::ADR_MASK && wb_sel_i[0]) s_next.mask = wb_dat_i[3:0];
    s_next.status = s_reg.status;
    if (wr && wb_adr_i == sfmc_pkg::ADR_STATUS && wb_sel_i[0])
      s_next.status = s_reg.status & ~wb_dat_i[3:0];
    s_next.status = s_next.status | ev;
    s_next.irq = |(s_next.status & s_next.mask);
    if (s_next.ack) begin
      unique case (wb_adr_i)
        sfmc_pkg::ADR_STATUS: s_next.dat = {28'h0, s_reg.status};
        sfmc_pkg::ADR_MASK:   s_next.dat = {28'h0, s_reg.mask};
        sfmc_pkg::ADR_STATE:  s_next.dat = {16'h0, 4'h0, s_reg.pwr, s_reg.learn,
                                            s_reg.learned, s_reg.ol_latch,
                                            s_reg.stall_latch, s_reg.fault_n};
        sfmc_pkg::ADR_THRESH: s_next.dat = {24'h0, s_reg.thresh};
        default:              s_next.dat = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.pwr <= sfmc_pkg::SFMC_PW_SLEEP;
      s_reg.learn <= sfmc_pkg::SFMC_LS_IDLE;
      s_reg.fault_n <= 1'b1;
      s_reg.rep_oe_n <= 1'b1;
      s_reg.outputs_hiz <= 1'b1;
      s_reg.th_drive <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state flops; report data tied low
  assign wb_dat_o = s_reg.dat;
  assign wb_ack_o = s_reg.ack;
  assign stall_report_out = 1'b0;
  assign stall_report_oe_n = s_reg.rep_oe_n;
  assign torque_threshold_pin = s_reg.th_out;
  assign torque_threshold_oe_n = !s_reg.th_drive;
  assign fault_out_n = s_reg.fault_n;
  assign bridge_enable = s_reg.bridge_on;
  assign outputs_hiz = s_reg.outputs_hiz;
  assign charge_pump_enable = s_reg.pump_on;
  assign core_logic_enable = s_reg.logic_on;
  assign inputs_ready = s_reg.inputs_ready;
  assign irq = s_reg.irq;

  // Checks
  sleep_delay_a: assert property (@(posedge clk) disable iff (rst)
    $fell(s_reg.logic_on) |-> $past(s_reg.low_cnt) == sfmc_pkg::CNT_W'(sfmc_pkg::SLEEP_DLY_CYC))
    else $error("sleep entered early");
  short_pulse_a: assert property (@(posedge clk) disable iff (rst)
    s_reg.pwr == sfmc_pkg::SFMC_PW_LOWPIN
    && s_reg.low_cnt != sfmc_pkg::CNT_W'(sfmc_pkg::SLEEP_DLY_CYC) |=> core_logic_enable)
    else $error("reset pulse dropped logic");
  disable_hiz_a: assert property (@(posedge clk) disable iff (rst)
    !enable_in |=> outputs_hiz && !bridge_enable)
    else $error("enable low but bridge on");
  ot_off_a: assert property (@(posedge clk) disable iff (rst)
    sense.over_temp |=> !charge_pump_enable && !bridge_enable && !fault_out_n)
    else $error("over temp not handled");
  sleep_off_a: assert property (@(posedge clk) disable iff (rst)
    s_reg.pwr == sfmc_pkg::SFMC_PW_SLEEP |-> !charge_pump_enable && !core_logic_enable)
    else $error("sleep left blocks on");
  dis_rep_a: assert property (@(posedge clk) disable iff (rst)
    stall_mode_select == sfmc_pkg::SFMC_SM_DISABLE |=> !stall_report_oe_n)
    else $error("disabled report not low");
  suspend_a: assert property (@(posedge clk) disable iff (rst)
    sense.over_temp |=> !$rose(s_reg.stall_latch))
    else $error("stall during fault");
  fault_out_a: assert property (@(posedge clk) disable iff (rst)
    s_reg.ol_latch |-> !fault_out_n)
    else $error("fault out high with open load");
  learn_rep_a: assert property (@(posedge clk) disable iff (rst)
    stall_mode_select == sfmc_pkg::SFMC_SM_LEARN
    ##1 s_reg.learn != sfmc_pkg::SFMC_LS_DONE |-> stall_report_oe_n)
    else $error("report low before learning done");
  wake_cov_c: cover property (@(posedge clk) disable iff (rst)
    s_reg.pwr == sfmc_pkg::SFMC_PW_WAKING ##1 s_reg.pwr == sfmc_pkg::SFMC_PW_ACTIVE);
  clr_cov_c: cover property (@(posedge clk) disable iff (rst)
    $fell(s_reg.ol_latch) && s_reg.logic_on);
  learn_cov_c: cover property (@(posedge clk) disable iff (rst)
    $rose(s_reg.learned));
endmodule
`default_nettype wire

// >>> sfmc_host_model.sv
// Host controller model driving the sleep, enable, mode and threshold pins
`timescale 1ns/100ps
`default_nettype none
module sfmc_host_model (
  // Clock
  input  wire logic                      clk,
  // Pins toward the block
  output logic                           sleep_in_n,
  output logic                           enable_in,
  output sfmc_pkg::sfmc_smode_type       stall_mode_select,
  output logic [sfmc_pkg::TH_W-1:0]      torque_threshold_in,
  output logic                           stall_report_in,
  // Pins from the block
  input  wire logic                      stall_report_oe_n,
  input  wire logic                      inputs_ready
);
  logic ext_hold;

  // Report wire has a pull-up, so it reads low while either side pulls
  assign stall_report_in = !(ext_hold || !stall_report_oe_n);

  // Idle pins: awake, enabled, torque count mode
  initial begin
    sleep_in_n = 1'b1;
    enable_in = 1'b1;
    stall_mode_select = sfmc_pkg::SFMC_SM_COUNT;
    torque_threshold_in = 8'h00;
    ext_hold = 1'b0;
  end

  // Pins change once the block takes inputs, or after 200 cycles; threshold under the seen count
  task automatic set_pins(input sfmc_pkg::sfmc_smode_type m, input logic hold,
                          input logic en, input logic [7:0] seen);
    int n;
    n = 0;
    while (inputs_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    stall_mode_select <= m;
    ext_hold <= hold;
    enable_in <= en;
    torque_threshold_in <= seen - (seen >> 2);
  endtask

  // Clearing pulse kept well inside the legal width window
  task automatic reset_pulse();
    @(posedge clk);
    sleep_in_n <= 1'b0;
    repeat (sfmc_pkg::PULSE_MIN_CYC + 500) @(posedge clk);
    sleep_in_n <= 1'b1;
  endtask

  // Long low level requests sleep
  task automatic go_sleep();
    @(posedge clk);
    sleep_in_n <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sfmc_pkg.sv
// Constants and carriers for the stepper fault and mode control block
package sfmc_pkg;
  localparam int CLK_MHZ        = 50;
  localparam int PULSE_MIN_US   = 20;
  localparam int PULSE_MAX_US   = 40;
  localparam int SLEEP_DLY_US   = 120;
  localparam int WAKE_DLY_US    = 1000;
  localparam int OL_DLY_US      = 100;
  localparam int PULSE_MIN_CYC  = PULSE_MIN_US * CLK_MHZ + 1;
  localparam int PULSE_MAX_CYC  = PULSE_MAX_US * CLK_MHZ;
  localparam int SLEEP_DLY_CYC  = SLEEP_DLY_US * CLK_MHZ;
  localparam int WAKE_DLY_CYC   = WAKE_DLY_US * CLK_MHZ;
  localparam int OL_DLY_CYC     = OL_DLY_US * CLK_MHZ;
  localparam int LEARN_RUN_CYC  = 32;
  localparam int LEARN_STALL_CYC = 16;
  localparam int CNT_W          = 17;
  localparam int EC_W           = 6;
  localparam int TH_W           = 8;

  // Register map (word addresses shown as bytes)
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_MASK   = 4'h4;
  localparam logic [3:0] ADR_STATE  = 4'h8;
  localparam logic [3:0] ADR_THRESH = 4'hc;
  localparam logic [3:0] EV_W       = 4'h4;
  localparam logic [3:0] EV_OL      = 4'h1;
  localparam logic [3:0] EV_OT      = 4'h2;
  localparam logic [3:0] EV_STALL   = 4'h4;
  localparam logic [3:0] EV_LEARN   = 4'h8;

  // Stall mode pin decode
  typedef enum logic [1:0] {
    SFMC_SM_COUNT   = 2'h0,
    SFMC_SM_THRESH  = 2'h1,
    SFMC_SM_LEARN   = 2'h2,
    SFMC_SM_DISABLE = 2'h3
  } sfmc_smode_type;

  // Power state, one hot
  typedef enum logic [3:0] {
    SFMC_PW_SLEEP  = 4'h1,
    SFMC_PW_WAKING = 4'h2,
    SFMC_PW_ACTIVE = 4'h4,
    SFMC_PW_LOWPIN = 4'h8
  } sfmc_pwr_type;

  // Learning sequence, one hot
  typedef enum logic [3:0] {
    SFMC_LS_IDLE  = 4'h1,
    SFMC_LS_RUN   = 4'h2,
    SFMC_LS_STALL = 4'h4,
    SFMC_LS_DONE  = 4'h8
  } sfmc_learn_type;

  // Analog-front-end observations
  typedef struct packed {
    logic            coil_low;
    logic            over_temp;
    logic            supply_low;
    logic            other_fault;
    logic            elec_cycle;
    logic            stall_seen;
    logic [TH_W-1:0] torque_count;
  } sfmc_sense_type;

  // Block state
  typedef struct packed {
    sfmc_pwr_type    pwr;
    sfmc_learn_type  learn;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] wake_cnt;
    logic [CNT_W-1:0] ol_cnt;
    logic [EC_W-1:0] ec_cnt;
    logic [TH_W-1:0] steady_cnt;
    logic [TH_W-1:0] thresh;
    logic            ol_latch;
    logic            stall_latch;
    logic            learned;
    logic [3:0]      status;
    logic [3:0]      mask;
    logic            irq;
    logic            fault_n;
    logic            rep_oe_n;
    logic            bridge_on;
    logic            outputs_hiz;
    logic            pump_on;
    logic            logic_on;
    logic            inputs_ready;
    logic            th_drive;
    logic [TH_W-1:0] th_out;
    logic            ack;
    logic [31:0]     dat;
  } sfmc_state_type;
endpackage

// >>> test_stepper_fault_mode_control.sv
// Self-checking bench for the stepper fault and mode control block
`timescale 1ns/100ps
`default_nettype none
module test_stepper_fault_mode_control;
  localparam int TIMEOUT_CYC = 90000;
  logic clk = 1'b0;
  logic rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic sleep_in_n, enable_in, stall_report_in, stall_report_oe_n;
  sfmc_pkg::sfmc_smode_type stall_mode_select;
  logic [7:0] torque_threshold_in, torque_threshold_pin, run_tc, stl_tc;
  sfmc_pkg::sfmc_sense_type sense;
  logic torque_threshold_oe_n, fault_out_n, bridge_enable, outputs_hiz;
  logic charge_pump_enable, core_logic_enable, inputs_ready, irq;
  int failures = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  logic [31:0] exp_q[$];

  sfmc_ctrl u_sfmc_ctrl (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_in_n, .enable_in,
    .stall_mode_select, .stall_report_in, .torque_threshold_in, .sense,
    .stall_report_out(), .stall_report_oe_n, .torque_threshold_pin,
    .torque_threshold_oe_n, .fault_out_n, .bridge_enable, .outputs_hiz,
    .charge_pump_enable, .core_logic_enable, .inputs_ready, .irq);
  sfmc_host_model u_sfmc_host_model (.clk, .sleep_in_n, .enable_in,
    .stall_mode_select, .torque_threshold_in, .stall_report_in,
    .stall_report_oe_n, .inputs_ready);

  always #10 clk = ~clk;

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Hang guard: a stuck wait ends the run as a failure
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == TIMEOUT_CYC) begin
      failures++;
      give_verdict();
    end
  end

  // Read data is judged at the ack edge against the oldest note
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      chk("read data", wb_dat_o, exp_q.pop_front());
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Classic cycle: held until ack is seen, then released for a cycle
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask

  // Electrical cycle pulses carrying a torque count
  task automatic ec(input int n, input logic [7:0] tc, input logic st);
    repeat (n) begin
      @(posedge clk);
      sense.elec_cycle <= 1'b1;
      sense.torque_count <= tc;
      sense.stall_seen <= st;
      @(posedge clk);
      sense.elec_cycle <= 1'b0;
      settle(2);
    end
  endtask

  // One stall under a given mode, then back to count mode and a clearing pulse
  task automatic stall_case(input sfmc_pkg::sfmc_smode_type m, input logic hold,
                            input logic oth, input logic eo, input logic ef);
    u_sfmc_host_model.set_pins(m, hold, 1'b1, 8'hc8);
    sense.other_fault <= oth;
    sense.torque_count <= 8'h00;
    sense.stall_seen <= 1'b1;
    settle(8);
    chk("report oe_n", stall_report_oe_n, eo);
    chk("fault_out_n", fault_out_n, ef);
    sense.stall_seen <= 1'b0;
    sense.other_fault <= 1'b0;
    sense.torque_count <= 8'hc8;
    u_sfmc_host_model.set_pins(sfmc_pkg::SFMC_SM_COUNT, 1'b0, 1'b1, 8'hc8);
    u_sfmc_host_model.reset_pulse();
    settle(4);
  endtask

  initial begin
    int n;
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    sense = '0;
    void'($urandom(32'h5c1a2c1b));
    settle(12);
    rst <= 1'b0;
    chk("fault_out_n", fault_out_n, 1'b1);
    chk("hiz", outputs_hiz, 1'b1);
    // Wake from reset, then registers and unmapped place
    n = 0;
    while (inputs_ready !== 1'b1 && n < sfmc_pkg::WAKE_DLY_CYC + 50) begin
      @(posedge clk);
      n++;
    end
    chk("wake time", 32'(n >= sfmc_pkg::WAKE_DLY_CYC - 2), 32'h1);
    chk("bridge", bridge_enable, 1'b1);
    chk("pump", charge_pump_enable, 1'b1);
    rd(4'h2, 32'h0);
    rd(sfmc_pkg::ADR_MASK, 32'h0);
    // Disable mode keeps logic, floats outputs
    u_sfmc_host_model.set_pins(sfmc_pkg::SFMC_SM_COUNT, 1'b0, 1'b0, 8'h00);
    settle(4);
    chk("hiz", outputs_hiz, 1'b1);
    chk("bridge", bridge_enable, 1'b0);
    chk("logic", core_logic_enable, 1'b1);
    u_sfmc_host_model.set_pins(sfmc_pkg::SFMC_SM_COUNT, 1'b0, 1'b1, 8'h00);
    settle(4);
    chk("hiz", outputs_hiz, 1'b0);
    // Open load latches, raises the interrupt, cleared by the pulse
    sense.coil_low <= 1'b1;
    settle(sfmc_pkg::OL_DLY_CYC + 20);
    chk("fault_out_n", fault_out_n, 1'b0);
    chk("bridge", bridge_enable, 1'b1);
    sense.coil_low <= 1'b0;
    settle(4);
    chk("fault_out_n", fault_out_n, 1'b0);
    rd(sfmc_pkg::ADR_STATUS, 32'(sfmc_pkg::EV_OL));
    wb(1'b1, sfmc_pkg::ADR_MASK, 32'(sfmc_pkg::EV_OL));
    rd(sfmc_pkg::ADR_MASK, 32'(sfmc_pkg::EV_OL));
    chk("irq", irq, 1'b1);
    u_sfmc_host_model.reset_pulse();
    settle(4);
    chk("fault_out_n", fault_out_n, 1'b1);
    chk("pump", charge_pump_enable, 1'b1);
    chk("logic", core_logic_enable, 1'b1);
    wb(1'b1, sfmc_pkg::ADR_STATUS, 32'(sfmc_pkg::EV_OL));
    settle(2);
    chk("irq", irq, 1'b0);
    rd(sfmc_pkg::ADR_STATUS, 32'h0);
    // Over temperature: bridge and pump off, automatic recovery
    sense.over_temp <= 1'b1;
    sense.stall_seen <= 1'b1;
    settle(4);
    chk("bridge", bridge_enable, 1'b0);
    chk("pump", charge_pump_enable, 1'b0);
    chk("fault_out_n", fault_out_n, 1'b0);
    sense.over_temp <= 1'b0;
    sense.stall_seen <= 1'b0;
    settle(4);
    chk("bridge", bridge_enable, 1'b1);
    chk("fault_out_n", fault_out_n, 1'b1);
    rd(sfmc_pkg::ADR_STATUS, 32'(sfmc_pkg::EV_OT));
    wb(1'b1, sfmc_pkg::ADR_STATUS, 32'h0000000f);
    // Stall under count, threshold and disable modes, with external hold and another fault
    stall_case(sfmc_pkg::SFMC_SM_COUNT, 1'b0, 1'b0, 1'b1, 1'b0);
    stall_case(sfmc_pkg::SFMC_SM_COUNT, 1'b1, 1'b0, 1'b1, 1'b1);
    stall_case(sfmc_pkg::SFMC_SM_THRESH, 1'b0, 1'b0, 1'b1, 1'b0);
    stall_case(sfmc_pkg::SFMC_SM_COUNT, 1'b0, 1'b1, 1'b0, 1'b0);
    stall_case(sfmc_pkg::SFMC_SM_DISABLE, 1'b0, 1'b0, 1'b0, 1'b1);
    // Learning: unloaded run then held stall, threshold is the mean
    run_tc = 8'h80 + 8'($urandom_range(127));
    stl_tc = 8'($urandom_range(63));
    u_sfmc_host_model.set_pins(sfmc_pkg::SFMC_SM_LEARN, 1'b0, 1'b1, 8'h00);
    ec(32, run_tc, 1'b0);
    chk("report oe_n", stall_report_oe_n, 1'b1);
    ec(16, stl_tc, 1'b1);
    sense.stall_seen <= 1'b0;
    settle(8);
    chk("report oe_n", stall_report_oe_n, 1'b0);
    chk("threshold oe_n", torque_threshold_oe_n, 1'b0);
    chk("threshold", torque_threshold_pin, (run_tc + stl_tc) >> 1);
    rd(sfmc_pkg::ADR_THRESH, 32'(({1'b0, run_tc} + {1'b0, stl_tc}) >> 1));
    rd(sfmc_pkg::ADR_STATUS, 32'(sfmc_pkg::EV_STALL | sfmc_pkg::EV_LEARN));
    rd(sfmc_pkg::ADR_STATE, {20'h0, sfmc_pkg::SFMC_PW_ACTIVE, sfmc_pkg::SFMC_LS_DONE,
       4'h9});
    // Sleep only once the sleep delay has run out
    u_sfmc_host_model.go_sleep();
    settle(sfmc_pkg::SLEEP_DLY_CYC - 4);
    chk("logic", core_logic_enable, 1'b1);
    settle(8);
    chk("logic", core_logic_enable, 1'b0);
    chk("pump", charge_pump_enable, 1'b0);
    chk("bridge", bridge_enable, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
